// ### hw/iosc_ctrl.sv
`timescale 1ns/1ps
`include "iosc_map.svh"
module iosc_ctrl #(
  parameter int unsigned OST_COUNT = `IOSC_OST_COUNT,
  parameter int unsigned START_CYC = `IOSC_START_CYC
)(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [2:0] i_osc_config_select,
  input wire logic i_two_speed_enable,
  input wire logic i_powerup_timer_en,
  input wire logic i_watchdog_timer_en,
  input wire logic i_failsafe_monitor_en,
  input wire logic i_display_lf_clk_en,
  input wire logic i_por_ready,
  input wire logic i_wake,
  input wire logic i_sleep,
  input wire logic i_ext_osc,
  input wire logic i_high_freq_internal_osc,
  input wire logic i_low_freq_internal_osc,
  output logic o_lf_osc_en,
  output logic o_hf_osc_en,
  output logic o_lf_timebase,
  output logic o_sys_clk,
  output logic o_cpu_hold,
  output logic o_external_clock_active
);
  iosc_pkg::iosc_regs_t r_reg;
  iosc_pkg::iosc_regs_t r_next;
  logic [2:0] lvl;
  logic [2:0] rise;
  logic [2:0] fall;
  logic crystal;
  logic int_mode;
  logic two_speed;
  logic lf_stable;
  logic hf_stable;
  logic cur_lvl;
  logic tgt_lvl;
  logic wb_hit;
  logic wb_wr;
  logic internal_freq_select_lf;
  logic [7:0] ctrl_rd;
  iosc_pkg::iosc_src_t int_src;
  iosc_pkg::iosc_src_t want;

  function automatic logic clk_level(
    input iosc_pkg::iosc_src_t s,
    input logic [2:0] f,
    input logic [2:0] l,
    input logic [`IOSC_POST_W-1:0] pc
  );
    logic v;
    v = 1'b0;
    case (s)
      iosc_pkg::SRC_LF: v = l[`IOSC_IDX_LF];
      // postscaler taps, 110 takes bit 0 (divide by 2)
      iosc_pkg::SRC_HF: v = (f == `IOSC_INTERNAL_FREQ_SELECT_8M) ? l[`IOSC_IDX_HF]
                                                  : pc[`IOSC_INTERNAL_FREQ_SELECT_8M - 3'h1 - f];
      iosc_pkg::SRC_EXT: v = l[`IOSC_IDX_EXT];
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  function automatic logic osc_ready(
    input iosc_pkg::iosc_src_t s,
    input logic lf_s,
    input logic hf_s
  );
    logic v;
    v = 1'b1;
    if (s == iosc_pkg::SRC_LF)
      v = lf_s;
    else if (s == iosc_pkg::SRC_HF)
      v = hf_s;
    return v;
  endfunction

  iosc_sync #(
    .W(3)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_async({i_low_freq_internal_osc, i_high_freq_internal_osc, i_ext_osc}),
    .o_level(lvl),
    .o_rise(rise),
    .o_fall(fall)
  );

  assign crystal = (i_osc_config_select == `IOSC_OSC_CONFIG_SELECT_LP) ||
                   (i_osc_config_select == `IOSC_OSC_CONFIG_SELECT_XT) ||
                   (i_osc_config_select == `IOSC_OSC_CONFIG_SELECT_HS);
  assign int_mode = (i_osc_config_select == `IOSC_OSC_CONFIG_SELECT_INTIO) ||
                    (i_osc_config_select == `IOSC_OSC_CONFIG_SELECT_INT);
  // two-speed only with enable, source 0 and a crystal mode
  // any non-crystal source leaves two-speed off
  assign two_speed = i_two_speed_enable && !r_reg.sysclk_source_select && crystal;
  // 000 selects the low osc, every other code the high osc
  assign internal_freq_select_lf = (r_reg.internal_freq_select == `IOSC_INTERNAL_FREQ_SELECT_LF);
  assign int_src = internal_freq_select_lf ? iosc_pkg::SRC_LF : iosc_pkg::SRC_HF;

  // source select steers between configured and internal clock
  // crystal still starting runs from internal when two-speed is on
  always_comb
  begin
    if (r_reg.sysclk_source_select || int_mode)
      want = int_src;
    else if (!crystal || r_reg.ost_done)
      want = iosc_pkg::SRC_EXT;
    else if (two_speed && r_reg.por_seen)
      want = int_src;
    else
      want = iosc_pkg::SRC_NONE;
  end

  assign o_lf_osc_en = ((r_reg.sysclk_source_select || i_two_speed_enable || int_mode) && internal_freq_select_lf) ||
                       i_powerup_timer_en || i_watchdog_timer_en ||
                       i_failsafe_monitor_en || i_display_lf_clk_en ||
                       (r_reg.src == iosc_pkg::SRC_LF) || (r_reg.tgt == iosc_pkg::SRC_LF);
  assign o_hf_osc_en = ((r_reg.sysclk_source_select || i_two_speed_enable || int_mode) && !internal_freq_select_lf) ||
                       (r_reg.src == iosc_pkg::SRC_HF) || (r_reg.tgt == iosc_pkg::SRC_HF);
  // synchronised low osc as timer time base
  assign o_lf_timebase = lvl[`IOSC_IDX_LF];

  // stability follows the live start-up counters
  assign lf_stable = (r_reg.lf_cnt == `IOSC_DLY_W'(START_CYC));
  assign hf_stable = (r_reg.hf_cnt == `IOSC_DLY_W'(START_CYC));

  assign cur_lvl = clk_level(r_reg.src, r_reg.internal_freq_select_app, lvl, r_reg.post_cnt);
  assign tgt_lvl = clk_level(r_reg.tgt, r_reg.tgt_internal_freq_select, lvl, r_reg.post_cnt);

  assign wb_hit = i_wb_cyc && i_wb_stb && !r_reg.ack;
  assign wb_wr = wb_hit && i_wb_we && i_wb_sel[0] && (i_wb_adr == `IOSC_OFS_CTRL);

  always_comb
  begin
    ctrl_rd = 8'h00;
    ctrl_rd[`IOSC_INTERNAL_FREQ_SELECT_MSB:`IOSC_INTERNAL_FREQ_SELECT_LSB] = r_reg.internal_freq_select;
    ctrl_rd[`IOSC_BIT_EXTERNAL_CLOCK_ACTIVE] = r_reg.external_clock_active;
    // high osc stable at bit 2
    ctrl_rd[`IOSC_BIT_HTS] = hf_stable;
    // low osc stable at bit 1
    ctrl_rd[`IOSC_BIT_LTS] = lf_stable;
    ctrl_rd[`IOSC_BIT_SCS] = r_reg.sysclk_source_select;
  end

  always_comb
  begin
    r_next = r_reg;
    r_next.cur_q = cur_lvl;
    r_next.tgt_q = tgt_lvl;
    r_next.ack = wb_hit;
    r_next.rdat = 8'h00;
    // unmapped reads answer zero
    if (wb_hit && !i_wb_we && (i_wb_adr == `IOSC_OFS_CTRL))
      r_next.rdat = ctrl_rd;
    // software frequency select; only software writes scs
    if (wb_wr)
    begin
      r_next.sysclk_source_select = i_wb_dat[`IOSC_BIT_SCS];
      r_next.internal_freq_select = i_wb_dat[`IOSC_INTERNAL_FREQ_SELECT_MSB:`IOSC_INTERNAL_FREQ_SELECT_LSB];
    end
    if (rise[`IOSC_IDX_HF])
      r_next.post_cnt = r_reg.post_cnt + `IOSC_POST_W'(1);
    // a stopped oscillator counts 10 us before it is usable
    if (!o_lf_osc_en)
      r_next.lf_cnt = '0;
    else if (!lf_stable)
      r_next.lf_cnt = r_reg.lf_cnt + `IOSC_DLY_W'(1);
    if (!o_hf_osc_en)
      r_next.hf_cnt = '0;
    else if (!hf_stable)
      r_next.hf_cnt = r_reg.hf_cnt + `IOSC_DLY_W'(1);
    // start-up restarts after power-up timer and after wake
    if ((i_por_ready && !r_reg.por_seen) || i_wake)
    begin
      r_next.por_seen = 1'b1;
      r_next.ost_run = 1'b1;
      r_next.ost_done = 1'b0;
      r_next.ost_cnt = '0;
    end
    // count external oscillations to the timeout
    else if (r_reg.ost_run && rise[`IOSC_IDX_EXT])
    begin
      r_next.ost_cnt = r_reg.ost_cnt + `IOSC_OST_W'(1);
      if (r_reg.ost_cnt == `IOSC_OST_W'(OST_COUNT - 1))
      begin
        r_next.ost_run = 1'b0;
        r_next.ost_done = 1'b1;
      end
    end
    if (i_sleep)
    begin
      r_next.ost_run = 1'b0;
      r_next.ost_done = 1'b0;
      r_next.ost_cnt = '0;
    end
    case (r_reg.st)
      iosc_pkg::ST_RUN:
      begin
        r_next.sys_clk = cur_lvl;
        if ((want != r_reg.src) ||
            ((want == iosc_pkg::SRC_HF) && (r_reg.internal_freq_select != r_reg.internal_freq_select_app)))
        begin
          r_next.tgt = want;
          r_next.tgt_internal_freq_select = r_reg.internal_freq_select;
          // high-osc derived targets skip the delay only while the high osc is stable
          if (osc_ready(want, lf_stable, hf_stable))
            r_next.st = iosc_pkg::ST_FALL;
          else
            r_next.st = iosc_pkg::ST_START;
        end
      end
      iosc_pkg::ST_START:
      begin
        r_next.sys_clk = cur_lvl;
        if (osc_ready(r_reg.tgt, lf_stable, hf_stable))
          r_next.st = iosc_pkg::ST_FALL;
      end
      iosc_pkg::ST_FALL:
      begin
        r_next.sys_clk = cur_lvl;
        // wait for the current clock to fall, then hold low
        if ((r_reg.src == iosc_pkg::SRC_NONE) || (r_reg.cur_q && !cur_lvl))
        begin
          r_next.sys_clk = 1'b0;
          r_next.st = iosc_pkg::ST_HOLD;
          // clock-active rises on the internal falling edge
          r_next.external_clock_active = (r_reg.tgt == iosc_pkg::SRC_EXT);
        end
      end
      default:
      begin
        r_next.sys_clk = 1'b0;
        // external joins on its falling edge, internal on its rising
        if ((r_reg.tgt == iosc_pkg::SRC_NONE) ||
            ((r_reg.tgt == iosc_pkg::SRC_EXT) ? (r_reg.tgt_q && !tgt_lvl)
                                              : (!r_reg.tgt_q && tgt_lvl)))
        begin
          r_next.src = r_reg.tgt;
          r_next.internal_freq_select_app = r_reg.tgt_internal_freq_select;
          r_next.st = iosc_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      r_reg <= '0;
      // reset selects 4 MHz; source select cleared
      r_reg.internal_freq_select <= `IOSC_INTERNAL_FREQ_SELECT_RST;
    end
    else
      r_reg <= r_next;
  end

  assign o_wb_ack = r_reg.ack;
  assign o_wb_dat = {24'h000000, r_reg.rdat};
  assign o_sys_clk = r_reg.sys_clk;
  // without a running source, execution stays suspended
  assign o_cpu_hold = (r_reg.src == iosc_pkg::SRC_NONE);
  assign o_external_clock_active = r_reg.external_clock_active;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_cur_fall;
    (r_reg.st == iosc_pkg::ST_FALL) && r_reg.cur_q && !cur_lvl;
  endsequence
  sequence s_held_low;
    (r_reg.st == iosc_pkg::ST_HOLD) && !o_sys_clk;
  endsequence

  chk_reset_defaults: assert property (
    !$past(i_resetn) |-> (r_reg.internal_freq_select == `IOSC_INTERNAL_FREQ_SELECT_RST) && !r_reg.sysclk_source_select
  ) else $error("reset values of select fields wrong");
  chk_scs_kept: assert property (
    !wb_wr |=> $stable(r_reg.sysclk_source_select)
  ) else $error("source select changed without a write");
  chk_lf_enable: assert property (
    (r_reg.sysclk_source_select && internal_freq_select_lf) || i_watchdog_timer_en |-> o_lf_osc_en
  ) else $error("low osc not enabled");
  chk_hf_enable: assert property (
    r_reg.sysclk_source_select && !internal_freq_select_lf |-> o_hf_osc_en
  ) else $error("high osc not enabled");
  chk_switch_steps: assert property (
    s_cur_fall |=> s_held_low
  ) else $error("clock not held low after fall");
  chk_hf_delay: assert property (
    (r_reg.st == iosc_pkg::ST_FALL) && (r_reg.tgt == iosc_pkg::SRC_HF) |-> hf_stable
  ) else $error("switched to unstable high osc");
  chk_external_clock_active_ext: assert property (
    (r_reg.src == iosc_pkg::SRC_EXT) && (r_reg.st == iosc_pkg::ST_RUN) |-> r_reg.external_clock_active
  ) else $error("external running without active bit");
  chk_sleep_abort: assert property (
    i_sleep && !i_wake |=> !r_reg.ost_run && !r_reg.ost_done
  ) else $error("sleep did not abort start-up");
  chk_ost_count: assert property (
    $rose(r_reg.ost_done) |-> $past(r_reg.ost_cnt) == `IOSC_OST_W'(OST_COUNT - 1)
  ) else $error("start-up timer ended at wrong count");
endmodule // iosc_ctrl

// ### hw/iosc_map.svh
// Behaviour
// - low osc runs for 31 kHz select, two-speed at 000, or timer/monitor/display use.
// - low osc level is the time base handed to power-up, watchdog and monitor.
// - bit 1 of oscillator_control shows low osc stable.
// - bits 6:4 choose one of eight internal frequencies.
// - every reset loads frequency select with 110, 4 MHz.
// - switching to a stopped oscillator waits 10 us before the new frequency applies.
// - switch waits current clock fall, holds clock low, connects on new rising edge (external on its falling edge).
// - stable bits always show the live state of each internal oscillator.
// - switches among high-osc derived frequencies take no start-up delay.
// - source select 0 uses configured oscillator, 1 uses internal selected frequency.
// - every reset clears the source select bit.
// - automatic switches never change source select; software reads clock-active bit.
// - bit 3 shows the system clock runs external; for crystals, start-up timer done.
// - sleep aborts external start-up and leaves the clock-active bit clear.
// - crystal modes count 1024 oscillations; without two-speed execution is held.
// - two-speed needs enable bit, source select 0 and a crystal mode.
// - two-speed starts after power-up timer expiry and after each wake-up.
// - non-crystal external sources disable two-speed start-up.
// - two-speed runs internal, then on timeout switches on internal then external falls.
// - high osc runs for non-000 select with source 1, or two-speed at non-000.
// - bit 2 of oscillator_control shows high osc stable.
`ifndef IOSC_MAP_SVH
`define IOSC_MAP_SVH
`define IOSC_OFS_CTRL 8'h00
`define IOSC_BIT_SCS 0
`define IOSC_BIT_LTS 1
`define IOSC_BIT_HTS 2
`define IOSC_BIT_EXTERNAL_CLOCK_ACTIVE 3
`define IOSC_INTERNAL_FREQ_SELECT_LSB 4
`define IOSC_INTERNAL_FREQ_SELECT_MSB 6
`define IOSC_INTERNAL_FREQ_SELECT_RST 3'h6
`define IOSC_INTERNAL_FREQ_SELECT_LF 3'h0
`define IOSC_INTERNAL_FREQ_SELECT_8M 3'h7
`define IOSC_OSC_CONFIG_SELECT_LP 3'h0
`define IOSC_OSC_CONFIG_SELECT_XT 3'h1
`define IOSC_OSC_CONFIG_SELECT_HS 3'h2
`define IOSC_OSC_CONFIG_SELECT_INTIO 3'h4
`define IOSC_OSC_CONFIG_SELECT_INT 3'h5
`define IOSC_IDX_EXT 0
`define IOSC_IDX_HF 1
`define IOSC_IDX_LF 2
`define IOSC_CLK_KHZ 50000
`define IOSC_START_NS 10000
`define IOSC_START_CYC ((`IOSC_START_NS * `IOSC_CLK_KHZ + 999999) / 1000000)
`define IOSC_OST_COUNT 1024
`define IOSC_OST_W 11
`define IOSC_DLY_W 10
`define IOSC_POST_W 7
`endif

// ### hw/iosc_pkg.sv
`include "iosc_map.svh"
package iosc_pkg;
  typedef enum logic [1:0]
  {
    ST_RUN = 2'h0,
    ST_START = 2'h1,
    ST_FALL = 2'h3,
    ST_HOLD = 2'h2
  } iosc_state_t;
  typedef enum logic [1:0]
  {
    SRC_NONE = 2'h0,
    SRC_LF = 2'h1,
    SRC_HF = 2'h2,
    SRC_EXT = 2'h3
  } iosc_src_t;
  typedef struct packed {
    iosc_state_t st;
    iosc_src_t src;
    iosc_src_t tgt;
    logic [2:0] internal_freq_select_app;
    logic [2:0] tgt_internal_freq_select;
    logic [2:0] internal_freq_select;
    logic sysclk_source_select;
    logic external_clock_active;
    logic por_seen;
    logic ost_run;
    logic ost_done;
    logic [`IOSC_OST_W-1:0] ost_cnt;
    logic [`IOSC_DLY_W-1:0] hf_cnt;
    logic [`IOSC_DLY_W-1:0] lf_cnt;
    logic [`IOSC_POST_W-1:0] post_cnt;
    logic cur_q;
    logic tgt_q;
    logic sys_clk;
    logic ack;
    logic [7:0] rdat;
  } iosc_regs_t;
endpackage

// ### hw/iosc_sync.sv
`timescale 1ns/1ps
module iosc_sync #(
  parameter int unsigned W = 3
)(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);
  typedef struct packed {
    logic [W-1:0] q1;
    logic [W-1:0] q2;
    logic [W-1:0] q3;
  } iosc_sync_t;
  iosc_sync_t r_reg;
  iosc_sync_t r_next;

  always_comb
  begin
    r_next.q1 = i_async;
    r_next.q2 = r_reg.q1;
    r_next.q3 = r_reg.q2;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  // edges come from q2/q3 only, q1 feeds nothing but q2
  assign o_level = r_reg.q2;
  assign o_rise = r_reg.q2 & ~r_reg.q3;
  assign o_fall = ~r_reg.q2 & r_reg.q3;
endmodule // iosc_sync

// ### tb/iosc_ctrl_tb.sv
`timescale 1ns/1ps
module iosc_ctrl_tb;
  localparam int OST_N = 8;
  localparam int START_N = 6;
  logic i_core_clk, i_resetn, cyc, stb, we, wb_ack;
  logic [7:0] adr;
  logic [3:0] sel, m;
  logic [31:0] wdat, rdat, wb_rd, d;
  logic [2:0] cfg, f;
  logic s, tse, powerup_timer, wdt, failsafe_clock_monitor, lcd, por, wake, slp, ext_run, hi, lo;
  logic ext_clk, hf_clk, lf_clk, lf_en, hf_en, tbase, sys_clk, hold, external_clock_active;
  int errors, num_checks, cycles, ext_cnt, seed, i, k;

  initial
  begin
    i_core_clk = 1'h0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  iosc_ctrl #(.OST_COUNT(OST_N), .START_CYC(START_N)) uut (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(wb_rd),
    .o_wb_ack(wb_ack), .i_osc_config_select(cfg), .i_two_speed_enable(tse),
    .i_powerup_timer_en(powerup_timer), .i_watchdog_timer_en(wdt), .i_failsafe_monitor_en(failsafe_clock_monitor),
    .i_display_lf_clk_en(lcd), .i_por_ready(por), .i_wake(wake), .i_sleep(slp),
    .i_ext_osc(ext_clk), .i_high_freq_internal_osc(hf_clk),
    .i_low_freq_internal_osc(lf_clk), .o_lf_osc_en(lf_en), .o_hf_osc_en(hf_en),
    .o_lf_timebase(tbase), .o_sys_clk(sys_clk), .o_cpu_hold(hold),
    .o_external_clock_active(external_clock_active)
  );

  iosc_osc_model osc (
    .i_ext_run(ext_run), .i_hf_en(hf_en), .i_lf_en(lf_en),
    .o_ext(ext_clk), .o_hf(hf_clk), .o_lf(lf_clk)
  );

  always @(posedge ext_clk) ext_cnt++;

  always @(posedge i_core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      end_sim();
    end
  end

  task end_sim;
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function logic [31:0] ctl(input logic [2:0] ff, input logic ss);
    return {24'h0, 1'h0, ff, 3'h0, ss};
  endfunction

  // ack is one cycle late by design, but the wait is open-ended up to a guard
  task wb(input logic w, input logic [31:0] dv, input logic [7:0] a, input logic [3:0] mk);
    int n;
    @(posedge i_core_clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= dv;
    sel <= mk;
    for (n = 0; n < 50 && wb_ack !== 1'h1; n++) @(posedge i_core_clk);
    rdat = wb_rd;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask

  task rd(input logic [7:0] a);
    wb(1'h0, 32'h0, a, 4'hF);
  endtask

  task wait_external_clock_active(input logic v);
    for (k = 0; k < 3000 && external_clock_active !== v; k++) @(posedge i_core_clk);
  endtask

  task poll(input int b, input logic v);
    for (k = 0; k < 60; k++)
    begin
      rd(8'h00);
      if (rdat[b] === v) break;
    end
    chk(rdat[b], v);
  endtask

  task do_reset(input logic [2:0] c);
    @(posedge i_core_clk);
    i_resetn <= 1'h0;
    cfg <= c;
    por <= 1'h0;
    repeat (6) @(posedge i_core_clk);
    i_resetn <= 1'h1;
  endtask

  initial
  begin
    {errors, num_checks, cycles, ext_cnt} = '0;
    seed = 32'h5cdc9388;
    {i_resetn, cyc, stb, we, adr, sel, wdat} = '0;
    {tse, powerup_timer, wdt, failsafe_clock_monitor, lcd, por, wake, slp} = '0;
    ext_run = 1'h1;
    cfg = 3'h1;
    tse = 1'h1;
    do_reset(3'h1);
    rd(8'h00);
    chk(rdat & 32'hF9, ctl(3'h6, 1'h0));
    rd(8'h04);
    chk(rdat, 32'h0);
    chk(hf_en, 1'h1);
    ext_cnt = 0;
    por <= 1'h1;
    wait_external_clock_active(1'h1);
    chk(external_clock_active, 1'h1);
    chk(ext_cnt >= OST_N, 1'h1);
    rd(8'h00);
    chk(rdat & 32'hF9, ctl(3'h6, 1'h0) | 32'h8);
    chk(hold, 1'h0);
    // sleep right after wake aborts start-up; crystal keeps running so the
    // switch back to internal can see its falling edge
    @(posedge i_core_clk);
    wake <= 1'h1;
    @(posedge i_core_clk);
    wake <= 1'h0;
    slp <= 1'h1;
    @(posedge i_core_clk);
    slp <= 1'h0;
    repeat (400) @(posedge i_core_clk);
    chk(external_clock_active, 1'h0);
    wake <= 1'h1;
    @(posedge i_core_clk);
    wake <= 1'h0;
    wait_external_clock_active(1'h1);
    chk(external_clock_active, 1'h1);
    f = 3'h6;
    s = 1'h0;
    for (i = 0; i < 14; i++)
    begin
      d = $random(seed);
      m = (i == 0) ? 4'hE : 4'($random(seed));
      wb(1'h1, d, 8'h00, m);
      if (m[0])
      begin
        f = d[6:4];
        s = d[0];
      end
      rd(8'h00);
      chk(rdat & 32'hF1, ctl(f, s));
    end
    wb(1'h1, ctl(3'h7, 1'h1), 8'h00, 4'hF);
    wait_external_clock_active(1'h0);
    chk(external_clock_active, 1'h0);
    chk(hf_en, 1'h1);
    wb(1'h1, ctl(3'h0, 1'h1), 8'h00, 4'hF);
    chk(lf_en, 1'h1);
    poll(1, 1'h1);
    {hi, lo} = '0;
    for (i = 0; i < 200; i++)
    begin
      @(posedge i_core_clk);
      hi = hi | (tbase === 1'h1);
      lo = lo | (tbase === 1'h0);
    end
    chk({hi, lo}, 2'h3);
    // non-crystal source, two-speed bit off: neither oscillator is needed
    tse <= 1'h0;
    do_reset(3'h3);
    por <= 1'h1;
    rd(8'h00);
    chk(rdat & 32'hF1, ctl(3'h6, 1'h0));
    chk(hf_en, 1'h0);
    chk(lf_en, 1'h0);
    wdt <= 1'h1;
    repeat (3) @(posedge i_core_clk);
    chk(lf_en, 1'h1);
    wb(1'h1, ctl(3'h0, 1'h1), 8'h00, 4'hF);
    repeat (100) @(posedge i_core_clk);
    chk(hf_en, 1'h0);
    wb(1'h1, ctl(3'h7, 1'h1), 8'h00, 4'hF);
    rd(8'h00);
    chk(rdat[2], 1'h0);
    poll(2, 1'h1);
    wb(1'h1, ctl(3'h5, 1'h1), 8'h00, 4'hF);
    rd(8'h00);
    chk(rdat[2], 1'h1);
    end_sim();
  end
endmodule // iosc_ctrl_tb

// ### tb/iosc_osc_model.sv
`timescale 1ns/1ps
module iosc_osc_model #(
  parameter int EXT_HALF = 100,
  parameter int HF_HALF = 70,
  parameter int LF_HALF = 310
)(
  input wire logic i_ext_run,
  input wire logic i_hf_en,
  input wire logic i_lf_en,
  output logic o_ext,
  output logic o_hf,
  output logic o_lf
);
  // a stopped source sits low, so no stale edge reaches the syncs
  initial
  begin
    o_ext = 1'h0;
    o_hf = 1'h0;
    o_lf = 1'h0;
  end
  always #(EXT_HALF) o_ext = i_ext_run ? ~o_ext : 1'h0;
  always #(HF_HALF) o_hf = i_hf_en ? ~o_hf : 1'h0;
  always #(LF_HALF) o_lf = i_lf_en ? ~o_lf : 1'h0;
endmodule // iosc_osc_model
